// file: wdt_window_cfg.svh
// Constants for the windowed watchdog control and status block
`ifndef WDT_WINDOW_CFG_SVH
`define WDT_WINDOW_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define WDT_OFS_CONTROL_TWO 8'h00
`define WDT_OFS_PRESCALE_LOW 8'h04
`define WDT_OFS_PRESCALE_HIGH 8'h08
`define WDT_OFS_TIMER_STATUS 8'h0c
`define WDT_OFS_EVENT_STATUS 8'h10
`define WDT_OFS_EVENT_MASK 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDT_CS_HI 6
`define WDT_CS_LO 4
`define WDT_WIN_HI 2
`define WDT_WIN_LO 0
`define WDT_TMR_HI 6
`define WDT_TMR_LO 3
`define WDT_ARMED_BIT 2
`define WDT_PS_TOP_HI 1
`define WDT_PS_TOP_LO 0
`define WDT_EV_TIMEOUT 0
`define WDT_EV_VIOLATION 1

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define WDT_FUSE_SOFT 3'h7
`define WDT_CS_LOW_FREQ 3'h0
`define WDT_CS_MED_FREQ 3'h1
`define WDT_WIN_RESET 3'h7
`define WDT_PS_SEL_MAX 5'h12
`define WDT_PS_SEL_MIN 5'h00
`define WDT_COUNT_LAST 5'h1f
`define WDT_EVENT_RESET 2'h0
`define WDT_MASK_RESET 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDT_CLK_HZ 100000000
`define WDT_LOW_FREQ_HZ 31000
`define WDT_MED_FREQ_HZ 31250
`define WDT_LOW_FREQ_DIV (`WDT_CLK_HZ / `WDT_LOW_FREQ_HZ)
`define WDT_MED_FREQ_DIV (`WDT_CLK_HZ / `WDT_MED_FREQ_HZ)

`endif

// file: wdt_window_pkg.sv
// Types for the windowed watchdog control and status block
package wdt_window_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_t;

    typedef struct packed {
        bus_state_t busState;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic loadPending;
        logic [2:0] timebaseSourceSelect;
        logic [2:0] windowSelect;
        logic [17:0] prescaleLiveCount;
        logic [4:0] wdtCount;
        logic armed;
        logic [1:0] events;
        logic [1:0] mask;
        logic irq;
        logic wdtReset;
    } wdt_state_t;

endpackage

// file: wdt_tick_divider.sv
// Divider that turns the system clock into a one-cycle tick enable
module wdt_tick_divider #(
    parameter int DIVIDE = 3200
) (
    input wire logic clock,
    input wire logic reset_n,
    output logic tick
);
    localparam int CW = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (count_q == LAST);
            if (count_q == LAST) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + CW'(1);
            end
        end
    end
endmodule

// file: watchdog_window_clock_status.sv
// Windowed watchdog: clock and window select, live counters, APB access
`include "wdt_window_cfg.svh"

module watchdog_window_clock_status
    import wdt_window_pkg::*;
#(
    parameter int LOW_FREQ_DIV = `WDT_LOW_FREQ_DIV,
    parameter int MED_FREQ_DIV = `WDT_MED_FREQ_DIV
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] fuseTimebaseSource,
    input wire logic [2:0] fuseOpenSpanSize,
    input wire logic [4:0] timeoutPrescaleSelect,
    input wire logic watchdogActive,
    input wire logic windowedMode,
    input wire logic controlOneRead,
    input wire logic controlOneWrite,
    input wire logic watchdogClearCommand,
    input wire logic sleepEnter,
    input wire logic sleepExit,
    input wire logic oscStartupRunning,
    output logic watchdogResetPulse,
    output logic irq
);

    // ------------------------------------------------------------
    // Oscillator time bases
    // ------------------------------------------------------------
    logic lowFreqTick;
    logic medFreqTick;

    wdt_tick_divider #(
        .DIVIDE(LOW_FREQ_DIV)
    ) lowFreqDivider (
        .clock(clock),
        .reset_n(reset_n),
        .tick(lowFreqTick)
    );

    wdt_tick_divider #(
        .DIVIDE(MED_FREQ_DIV)
    ) medFreqDivider (
        .clock(clock),
        .reset_n(reset_n),
        .tick(medFreqTick)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    wdt_state_t s_q;
    wdt_state_t s_d;

    logic clockSelSoft;
    logic windowSelSoft;
    logic [2:0] effClockSel;
    logic [2:0] effWindowSel;
    logic timeTick;
    logic [4:0] psSel;
    logic [18:0] stepEnd;
    logic stepDone;
    logic [2:0] delayEighths;
    logic windowOpen;
    logic hit;
    logic [31:0] readData;
    logic commit;
    logic writeCommit;
    logic writeControlTwo;
    logic clearRequest;
    logic violation;
    logic timeout;
    logic counterClear;
    logic [1:0] eventSet;
    logic [1:0] eventClear;

    // ------------------------------------------------------------
    // Selection and window decode
    // ------------------------------------------------------------
    always_comb begin
        clockSelSoft = (fuseTimebaseSource == `WDT_FUSE_SOFT);
        windowSelSoft = (fuseOpenSpanSize == `WDT_FUSE_SOFT);
        // Locked fields follow the fuse; the register mirrors it
        effClockSel = clockSelSoft ? s_q.timebaseSourceSelect
                                   : fuseTimebaseSource;
        effWindowSel = windowSelSoft ? s_q.windowSelect
                                     : fuseOpenSpanSize;
        case (effClockSel)
            `WDT_CS_LOW_FREQ: timeTick = lowFreqTick;
            `WDT_CS_MED_FREQ: timeTick = medFreqTick;
            default: timeTick = 1'b0;
        endcase
        // Reserved prescale codes fall back to the shortest interval
        psSel = (timeoutPrescaleSelect > `WDT_PS_SEL_MAX)
              ? `WDT_PS_SEL_MIN : timeoutPrescaleSelect;
        stepEnd = (19'h1 << psSel) - 19'h1;
        stepDone = timeTick && (s_q.prescaleLiveCount == stepEnd[17:0]);
        // Closed span in eighths is the code's distance below 111
        delayEighths = `WDT_WIN_RESET - effWindowSel;
        windowOpen = (s_q.wdtCount[4:2] >= delayEighths);
    end

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    always_comb begin
        readData = 32'h0;
        hit = 1'b1;
        case (paddr)
            `WDT_OFS_CONTROL_TWO: begin
                // Bits 7 and 3 stay zero
                readData[`WDT_CS_HI:`WDT_CS_LO] =
                    s_q.timebaseSourceSelect;
                readData[`WDT_WIN_HI:`WDT_WIN_LO] = s_q.windowSelect;
            end
            `WDT_OFS_PRESCALE_LOW: begin
                readData[7:0] = s_q.prescaleLiveCount[7:0];
            end
            `WDT_OFS_PRESCALE_HIGH: begin
                readData[7:0] = s_q.prescaleLiveCount[15:8];
            end
            `WDT_OFS_TIMER_STATUS: begin
                readData[`WDT_TMR_HI:`WDT_TMR_LO] =
                    s_q.wdtCount[4:1];
                readData[`WDT_ARMED_BIT] = s_q.armed;
                readData[`WDT_PS_TOP_HI:`WDT_PS_TOP_LO] =
                    s_q.prescaleLiveCount[17:16];
            end
            `WDT_OFS_EVENT_STATUS: begin
                readData[1:0] = s_q.events;
            end
            `WDT_OFS_EVENT_MASK: begin
                readData[1:0] = s_q.mask;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.wdtReset = 1'b0;

        // Write lands at the edge where the master sees pready
        commit = psel && penable && s_q.pready;
        writeCommit = commit && pwrite && !s_q.pslverr;
        writeControlTwo = writeCommit
                       && (paddr == `WDT_OFS_CONTROL_TWO);

        // APB slave: one wait state, answer registered
        case (s_q.busState)
            BUS_IDLE: begin
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
                if (psel && penable) begin
                    s_d.busState = BUS_DONE;
                    s_d.pready = 1'b1;
                    s_d.pslverr = !hit;
                    s_d.prdata = pwrite ? 32'h0 : readData;
                end
            end
            BUS_DONE: begin
                s_d.busState = BUS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
            default: begin
                s_d.busState = BUS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
        endcase

        // Fuse values captured on the first cycle after reset
        if (s_q.loadPending) begin
            s_d.loadPending = 1'b0;
            s_d.timebaseSourceSelect = clockSelSoft
                ? `WDT_CS_LOW_FREQ : fuseTimebaseSource;
            s_d.windowSelect = fuseOpenSpanSize;
        end else if (writeControlTwo) begin
            if (clockSelSoft) begin
                s_d.timebaseSourceSelect =
                    pwdata[`WDT_CS_HI:`WDT_CS_LO];
            end
            if (windowSelSoft) begin
                s_d.windowSelect =
                    pwdata[`WDT_WIN_HI:`WDT_WIN_LO];
            end
        end

        // Clear command: windowed mode needs arming and an open window
        clearRequest = watchdogClearCommand && watchdogActive;
        violation = clearRequest && windowedMode
                 && (!s_q.armed || !windowOpen);
        timeout = watchdogActive && stepDone
               && (s_q.wdtCount == `WDT_COUNT_LAST);

        counterClear = clearRequest || timeout || !watchdogActive
                    || sleepEnter || sleepExit || oscStartupRunning
                    || writeControlTwo || controlOneWrite;

        // Prescaler and watchdog counter
        if (counterClear) begin
            s_d.prescaleLiveCount = 18'h0;
            s_d.wdtCount = 5'h0;
        end else if (timeTick) begin
            if (stepDone) begin
                s_d.prescaleLiveCount = 18'h0;
                s_d.wdtCount = s_q.wdtCount + 5'h1;
            end else begin
                s_d.prescaleLiveCount = s_q.prescaleLiveCount + 18'h1;
            end
        end

        // Arming: a read of control one arms in windowed mode; any counter clear disarms
        if (counterClear) begin
            s_d.armed = 1'b0;
        end else if (controlOneRead && windowedMode) begin
            s_d.armed = 1'b1;
        end

        // Time-out and violation both reset the device
        if (timeout || violation) begin
            s_d.wdtReset = 1'b1;
        end

        // Sticky events, write one to clear, a new event wins
        eventSet = 2'h0;
        eventSet[`WDT_EV_TIMEOUT] = timeout;
        eventSet[`WDT_EV_VIOLATION] = violation;
        eventClear = 2'h0;
        if (writeCommit && (paddr == `WDT_OFS_EVENT_STATUS)) begin
            eventClear = pwdata[1:0];
        end
        s_d.events = (s_q.events & ~eventClear) | eventSet;
        if (writeCommit && (paddr == `WDT_OFS_EVENT_MASK)) begin
            s_d.mask = pwdata[1:0];
        end
        s_d.irq = |(s_d.events & s_d.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q.busState <= BUS_IDLE;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= 32'h0;
            s_q.loadPending <= 1'b1;
            s_q.timebaseSourceSelect <= `WDT_CS_LOW_FREQ;
            s_q.windowSelect <= `WDT_WIN_RESET;
            s_q.prescaleLiveCount <= 18'h0;
            s_q.wdtCount <= 5'h0;
            s_q.armed <= 1'b0;
            s_q.events <= `WDT_EVENT_RESET;
            s_q.mask <= `WDT_MASK_RESET;
            s_q.irq <= 1'b0;
            s_q.wdtReset <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;
    assign watchdogResetPulse = s_q.wdtReset;

endmodule

// file: wdt_window_assertions.sv
// Port-level checks of the windowed watchdog control and status block
module wdt_window_assertions
    import wdt_window_pkg::*;
#(
    parameter int LOW_FREQ_DIV = 3225,
    parameter int MED_FREQ_DIV = 3200
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] fuseTimebaseSource,
    input wire logic [2:0] fuseOpenSpanSize,
    input wire logic watchdogActive,
    input wire logic watchdogResetPulse
);
    // ------------------------------------------------------------
    // Bus answer, read layout, fuse locks and reset pulse
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic rdCtl, rdSts;
    assign rdCtl = pready && !pwrite && paddr == 8'h00;
    assign rdSts = pready && !pwrite && paddr == 8'h0c;
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("answer held too long");
    a_unmapped_err: assert property (pready && paddr > 8'h14 |->
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property (pready && paddr <= 8'h14 &&
        paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
    a_ctl_unused_zero: assert property (rdCtl |->
        prdata[31:7] == 25'h0 && !prdata[3]) else $error("ctl unused set");
    a_sts_unused_zero: assert property (rdSts |->
        prdata[31:7] == 25'h0) else $error("status unused set");
    a_byte_upper_zero: assert property (pready && !pwrite &&
        (paddr == 8'h04 || paddr == 8'h08) |-> prdata[31:8] == 24'h0)
        else $error("prescale byte upper bits set");
    a_cs_locked: assert property (rdCtl &&
        fuseTimebaseSource != 3'h7 |-> prdata[6:4] == fuseTimebaseSource)
        else $error("clock select moved");
    a_win_locked: assert property (rdCtl &&
        fuseOpenSpanSize != 3'h7 |-> prdata[2:0] == fuseOpenSpanSize)
        else $error("window select moved");
    a_reset_single: assert property (watchdogResetPulse |=>
        !watchdogResetPulse) else $error("reset pulse too long");
    a_idle_no_reset: assert property (!watchdogActive ##1
        !watchdogActive |=> !watchdogResetPulse)
        else $error("reset while disabled");
endmodule

// file: tb.sv
// Self-checking bench of the windowed watchdog control and status block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, wd;
    logic pready, pslverr, watchdogResetPulse, irq, err;
    logic [2:0] fuseTimebaseSource = 3'h7, fuseOpenSpanSize = 3'h7, fc, fw;
    logic [4:0] timeoutPrescaleSelect = 5'h00;
    logic watchdogActive = 0, windowedMode = 0, controlOneRead = 0;
    logic controlOneWrite = 0, watchdogClearCommand = 0, sleepEnter = 0;
    logic sleepExit = 0, oscStartupRunning = 0;
    int fails = 0, n_tests = 0, cycles = 0, c, w;
    localparam int LDIV = 4;
    localparam int MDIV = 5;
    watchdog_window_clock_status #(.LOW_FREQ_DIV(LDIV), .MED_FREQ_DIV(MDIV))
    watchdog_window_clock_status_inst (.clock(clock), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fuseTimebaseSource(fuseTimebaseSource),
        .fuseOpenSpanSize(fuseOpenSpanSize),
        .timeoutPrescaleSelect(timeoutPrescaleSelect),
        .watchdogActive(watchdogActive), .windowedMode(windowedMode),
        .controlOneRead(controlOneRead), .controlOneWrite(controlOneWrite),
        .watchdogClearCommand(watchdogClearCommand), .sleepEnter(sleepEnter),
        .sleepExit(sleepExit), .oscStartupRunning(oscStartupRunning),
        .watchdogResetPulse(watchdogResetPulse), .irq(irq));
    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic check_range(input int got, lo, hi, input string what);
        n_tests++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected at %0t: %s %0d", $time, what, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        check({31'h0, pready}, 1, "ready");
    endtask
    task automatic pulse(input int k);
        @(posedge clock);
        case (k)
            0: watchdogClearCommand <= 1;
            1: sleepEnter <= 1;
            2: sleepExit <= 1;
            3: controlOneWrite <= 1;
            4: oscStartupRunning <= 1;
            default: controlOneRead <= 1;
        endcase
        @(posedge clock);
        {watchdogClearCommand, sleepEnter, sleepExit, controlOneWrite,
            oscStartupRunning, controlOneRead} <= 6'h00;
    endtask
    task automatic do_reset(input logic [2:0] tc, tw);
        reset_n <= 0;
        {fuseTimebaseSource, fuseOpenSpanSize} <= {tc, tw};
        repeat (20) @(posedge clock);
        reset_n <= 1;
        repeat (2) @(posedge clock);
    endtask
    task automatic wait_reset(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (watchdogResetPulse !== 1'b1 && n < 400);
    endtask
    function automatic logic [31:0] ctl_exp(logic [2:0] tc, tw,
        logic [31:0] d, logic written);
        logic [2:0] cs, win;
        cs = tc != 3'h7 ? tc : (written ? d[6:4] : 3'h0);
        win = tw != 3'h7 ? tw : (written ? d[2:0] : 3'h7);
        return {25'h0, cs, 1'b0, win};
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(50));
        do_reset(3'h7, 3'h7);
        apb(0, 8'h00, 0);
        check(rd, ctl_exp(3'h7, 3'h7, 0, 0), "ctl reset");
        for (int a = 4; a <= 12; a += 4) begin
            apb(0, a[7:0], 0);
            check(rd, 0, "count reset");
        end
        apb(1, 8'h18, 32'hffffffff);
        check({31'h0, err}, 1, "unmapped");
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            fc = i[0] ? 3'h7 : 3'($urandom_range(0, 6));
            fw = i[1] ? 3'h7 : 3'($urandom_range(0, 6));
            do_reset(fc, fw);
            apb(0, 8'h00, 0);
            check(rd, ctl_exp(fc, fw, 0, 0), "fuse load");
            wd = $urandom;
            apb(1, 8'h00, wd);
            apb(0, 8'h00, 0);
            check(rd, ctl_exp(fc, fw, wd, 1), "lock");
        end
        do_reset(3'h7, 3'h7);
        $display("test fuse locks done");
        watchdogActive <= 1;
        for (int cs = 0; cs < 3; cs++) begin
            w = cs == 0 ? LDIV : MDIV;
            apb(1, 8'h00, 32'h07 | (cs << 4));
            pulse(0);
            wait_reset(c);
            if (cs < 2) begin
                check_range(c, 31 * w, 33 * w + 4, "period");
            end else begin
                check_range(c, 400, 400, "reserved");
            end
        end
        apb(0, 8'h10, 0);
        check(rd, 1, "timeout event");
        check({31'h0, irq}, 0, "masked irq");
        apb(1, 8'h14, 3);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 1, "irq");
        apb(1, 8'h10, 1);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 0, "irq cleared");
        $display("test time base done");
        apb(1, 8'h00, 32'h07);
        for (int k = 0; k < 5; k++) begin
            repeat (60) @(posedge clock);
            apb(0, 8'h0c, 0);
            check({31'h0, rd[6:3] != 4'h0}, 1, "counting");
            pulse(k);
            apb(0, 8'h0c, 0);
            check(rd[6:3], 0, "cleared");
        end
        timeoutPrescaleSelect <= 5'd10;
        // Stay below a low-byte carry so the two live byte reads agree
        w = $urandom_range(400, 900);
        pulse(0);
        repeat (w) @(posedge clock);
        apb(0, 8'h04, 0);
        wd[7:0] = rd[7:0];
        apb(0, 8'h08, 0);
        c = {rd[7:0], wd[7:0]};
        check_range(c, w / 4 - 2, w / 4 + 6, "prescale");
        apb(0, 8'h0c, 0);
        check(rd, 0, "status top");
        $display("test clears and prescale done");
        timeoutPrescaleSelect <= 5'd0;
        windowedMode <= 1;
        apb(1, 8'h00, 32'h07);
        pulse(0);
        wait_reset(c);
        check_range(c, 1, 3, "unarmed clear");
        pulse(5);
        apb(0, 8'h0c, 0);
        check(rd[2], 1, "armed");
        pulse(0);
        apb(0, 8'h0c, 0);
        check(rd[2], 0, "disarmed");
        wait_reset(c);
        check_range(c, 100, 140, "open clear");
        apb(1, 8'h00, 32'h00);
        pulse(5);
        pulse(0);
        wait_reset(c);
        check_range(c, 1, 3, "closed clear");
        apb(1, 8'h00, 32'h00);
        pulse(5);
        repeat (115) @(posedge clock);
        pulse(0);
        wait_reset(c);
        check_range(c, 100, 140, "late clear");
        apb(0, 8'h10, 0);
        check(rd[1], 1, "violation event");
        $display("test window done");
        test_done();
    end
endmodule
bind watchdog_window_clock_status wdt_window_assertions #(
    .LOW_FREQ_DIV(LOW_FREQ_DIV), .MED_FREQ_DIV(MED_FREQ_DIV))
wdt_window_assertions_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .fuseTimebaseSource(fuseTimebaseSource),
    .fuseOpenSpanSize(fuseOpenSpanSize), .watchdogActive(watchdogActive),
    .watchdogResetPulse(watchdogResetPulse));
